// *** verilog/ifd_consts.svh ***
// constants for the instruction format and cycle timing decoder
`ifndef IFD_CONSTS_SVH
`define IFD_CONSTS_SVH
`define IFD_WORD_W 24
`define IFD_OPC_W 8
`define IFD_OPC_LSB 16
`define IFD_OPC_NOP 8'h00
`define IFD_OPC_JUMP 8'h04
`define IFD_OPC_CALL 8'h02
`define IFD_OPC_MOVD 8'hbe
`define IFD_OPC_BRANCH_COND_LO 8'h30
`define IFD_OPC_BRANCH_COND_HI 8'h36
`define IFD_OPC_BRANCH_UNC 8'h37
`define IFD_OPC_BRANCH_COMP 8'h01
`define IFD_OPC_WORK_LO 8'h08
`define IFD_OPC_IND 8'h06
`define IFD_OPC_RET 8'h06
`define IFD_OPC_TBL_LO 8'hba
`define IFD_OPC_TBL_HI 8'hbb
`define IFD_OPC_SKIP_LO 8'ha6
`define IFD_OPC_SKIP_HI 8'ha7
`define IFD_OPC_FILE_LO 8'h40
`define IFD_OPC_FILE_HI 8'h7f
`define IFD_OPC_BIT_LO 8'ha0
`define IFD_OPC_BIT_HI 8'haf
`define IFD_OPC_LIT_LO 8'hb0
`define IFD_OPC_LIT_HI 8'hb7
`define IFD_FLD_W 4
`define IFD_FILE_W 13
`define IFD_LIT_W 5
`define IFD_DEST_BIT 13
`endif

// *** verilog/ifd_pkg.sv ***
// types for the instruction format and cycle timing decoder
package ifd_pkg;
	typedef enum logic [2:0] {
		IFD_CLS_NOP = 3'h0,
		IFD_CLS_WORK = 3'h1,
		IFD_CLS_FILE = 3'h2,
		IFD_CLS_BIT = 3'h3,
		IFD_CLS_LIT = 3'h4,
		IFD_CLS_CTRL = 3'h5
	} ifd_class_e;
	typedef enum logic [1:0] {
		IFD_ST_FIRST = 2'b00,
		IFD_ST_SECOND = 2'b01,
		IFD_ST_STALL = 2'b10
	} ifd_state_e;
endpackage : ifd_pkg

// *** verilog/ifd_field_split.sv ***
// operand field extraction for one instruction word
`timescale 1ns/1ps
`include "ifd_consts.svh"
module ifd_field_split (
	input wire logic [23:0] word_i,
	output logic [7:0] opcode_o,
	output logic [3:0] base_src_reg_o,
	output logic [3:0] second_src_reg_o,
	output logic [3:0] dest_reg_o,
	output logic [12:0] file_addr_o,
	output logic dest_is_file_o,
	output logic [4:0] literal_o
);
	always_comb begin
		opcode_o = word_i[`IFD_OPC_LSB +: `IFD_OPC_W];
		base_src_reg_o = word_i[14:11];
		dest_reg_o = word_i[10:7];
		second_src_reg_o = word_i[3:0];
		file_addr_o = word_i[12:0];
		dest_is_file_o = word_i[`IFD_DEST_BIT];
		literal_o = word_i[8:4];
	end
endmodule : ifd_field_split

// *** verilog/ifd_decoder.sv ***
// instruction word decoder with cycle timing
// Notes on behaviour
// - each single word is 24 bits; top 8 bits are the opcode.
// - exactly three instructions take two words; all others one word.
// - two-word instructions span 48 bits; second word top 8 bits zero.
// - a lone second word executes as a no-operation.
// - one cycle normally; two when a conditional branch finds its condition true.
// - branches, indirect jumps, table accesses and returns take extra cycles.
// - a taken skip costs two cycles, three over a two-word instruction.
// - every two-word instruction completes in two cycles.
// - working-register ops decode base, source and destination registers.
// - file-register ops decode file address and destination selector.
// - bit ops take bit position from literal or base register.
// - literal arithmetic takes base register and literal, optional destination.
`timescale 1ns/1ps
`include "ifd_consts.svh"
module ifd_decoder #(
	parameter int WORD_W = 24,
	parameter int TABLE_CYCLES = 2
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic word_valid_i,
	input wire logic [23:0] word_i,
	input wire logic cond_true_i,
	input wire logic bit_from_reg_i,
	output logic word_ready_o,
	output logic issue_o,
	output logic [7:0] opcode_o,
	output ifd_pkg::ifd_class_e class_o,
	output logic [3:0] base_src_reg_o,
	output logic [3:0] second_src_reg_o,
	output logic [3:0] dest_reg_o,
	output logic [12:0] file_addr_o,
	output logic dest_is_default_work_reg_zero_o,
	output logic [4:0] literal_o,
	output logic bit_from_base_src_reg_o,
	output logic write_dest_o,
	output logic [1:0] cycles_o,
	output logic is_two_word_o,
	output logic [47:0] long_word_o,
	output logic nop_o,
	output logic bad_second_o
);
	// refuse parameter values that the fixed field layout cannot serve
	if (WORD_W != `IFD_WORD_W) begin : g_bad_word_w
		$error("ifd_decoder: word width must be 24");
	end
	if (TABLE_CYCLES < 2 || TABLE_CYCLES > 3) begin : g_bad_table
		$error("ifd_decoder: table cycles 2 or 3");
	end

	ifd_pkg::ifd_state_e state_q;
	logic [1:0] stall_q;
	logic [23:0] first_q;
	logic skip_pending_q;
	logic [7:0] opc;
	logic [3:0] f_base, f_src, f_dest;
	logic [12:0] f_file;
	logic f_destsel;
	logic [4:0] f_lit;

	ifd_field_split u_split (
		.word_i(word_i),
		.opcode_o(opc),
		.base_src_reg_o(f_base),
		.second_src_reg_o(f_src),
		.dest_reg_o(f_dest),
		.file_addr_o(f_file),
		.dest_is_file_o(f_destsel),
		.literal_o(f_lit)
	);

	function automatic logic is_two_word(input logic [7:0] op);
		is_two_word = (op == `IFD_OPC_JUMP) || (op == `IFD_OPC_CALL) ||
			(op == `IFD_OPC_MOVD);
	endfunction : is_two_word

	function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo,
			input logic [7:0] hi);
		in_range = (op >= lo) && (op <= hi);
	endfunction : in_range

	logic accept;
	logic lone_second;
	logic [1:0] base_cycles;
	ifd_pkg::ifd_class_e cls;

	assign word_ready_o = (state_q != ifd_pkg::IFD_ST_STALL);
	assign accept = word_valid_i && word_ready_o;
	// a zero-opcode word outside the second slot is an orphan second word
	assign lone_second = (state_q == ifd_pkg::IFD_ST_FIRST) && (opc == `IFD_OPC_NOP);

	always_comb begin
		cls = ifd_pkg::IFD_CLS_CTRL;
		if (opc == `IFD_OPC_NOP) cls = ifd_pkg::IFD_CLS_NOP;
		else if (in_range(opc, `IFD_OPC_FILE_LO, `IFD_OPC_FILE_HI)) cls = ifd_pkg::IFD_CLS_FILE;
		else if (in_range(opc, `IFD_OPC_BIT_LO, `IFD_OPC_BIT_HI)) cls = ifd_pkg::IFD_CLS_BIT;
		else if (in_range(opc, `IFD_OPC_LIT_LO, `IFD_OPC_LIT_HI)) cls = ifd_pkg::IFD_CLS_LIT;
		else if (opc >= `IFD_OPC_WORK_LO) cls = ifd_pkg::IFD_CLS_WORK;
	end

	always_comb begin
		base_cycles = 2'd1;
		if (is_two_word(opc)) base_cycles = 2'd2;
		else if (opc == `IFD_OPC_BRANCH_UNC || opc == `IFD_OPC_BRANCH_COMP ||
				opc == `IFD_OPC_IND) base_cycles = 2'd2;
		else if (in_range(opc, `IFD_OPC_TBL_LO, `IFD_OPC_TBL_HI))
			base_cycles = TABLE_CYCLES[1:0];
		else if (in_range(opc, `IFD_OPC_BRANCH_COND_LO, `IFD_OPC_BRANCH_COND_HI) && cond_true_i)
			base_cycles = 2'd2;
	end

	// pipeline state: stalls model the extra no-operation cycles
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ifd_pkg::IFD_ST_FIRST;
			stall_q <= 2'd0;
		end else begin
			unique case (state_q)
				ifd_pkg::IFD_ST_FIRST: begin
					if (accept && !lone_second && !skip_pending_q) begin
						if (is_two_word(opc)) state_q <= ifd_pkg::IFD_ST_SECOND;
						else if (base_cycles > 2'd1) begin
							state_q <= ifd_pkg::IFD_ST_STALL;
							stall_q <= base_cycles - 2'd1;
						end
					end
				end
				ifd_pkg::IFD_ST_SECOND: begin
					if (accept) begin
						state_q <= ifd_pkg::IFD_ST_STALL;
						stall_q <= 2'd1;
					end
				end
				ifd_pkg::IFD_ST_STALL: begin
					if (stall_q <= 2'd1) state_q <= ifd_pkg::IFD_ST_FIRST;
					stall_q <= stall_q - 2'd1;
				end
				default: state_q <= ifd_pkg::IFD_ST_FIRST;
			endcase
		end
	end

	// skip bookkeeping: the skipped word and its second word both become nops
	logic skip_taken;
	assign skip_taken = (state_q == ifd_pkg::IFD_ST_FIRST) && accept && !skip_pending_q &&
		in_range(opc, `IFD_OPC_SKIP_LO, `IFD_OPC_SKIP_HI) && cond_true_i;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) skip_pending_q <= 1'b0;
		else if (skip_taken) skip_pending_q <= 1'b1;
		else if (accept && state_q == ifd_pkg::IFD_ST_FIRST && skip_pending_q &&
				!is_two_word(opc)) skip_pending_q <= 1'b0;
		else if (accept && state_q == ifd_pkg::IFD_ST_SECOND) skip_pending_q <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) first_q <= 24'h000000;
		else if (accept && state_q == ifd_pkg::IFD_ST_FIRST) first_q <= word_i;
	end

	// registered decode outputs
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			issue_o <= 1'b0;
			opcode_o <= 8'h00;
			class_o <= ifd_pkg::IFD_CLS_NOP;
			base_src_reg_o <= 4'h0;
			second_src_reg_o <= 4'h0;
			dest_reg_o <= 4'h0;
			file_addr_o <= 13'h0000;
			dest_is_default_work_reg_zero_o <= 1'b0;
			literal_o <= 5'h00;
			bit_from_base_src_reg_o <= 1'b0;
			write_dest_o <= 1'b0;
			cycles_o <= 2'd0;
			is_two_word_o <= 1'b0;
			long_word_o <= 48'h000000000000;
			nop_o <= 1'b0;
			bad_second_o <= 1'b0;
		end else begin
			issue_o <= 1'b0;
			bad_second_o <= 1'b0;
			if (accept && state_q == ifd_pkg::IFD_ST_FIRST) begin
				issue_o <= !is_two_word(opc) || skip_pending_q;
				opcode_o <= opc;
				class_o <= (lone_second || skip_pending_q) ? ifd_pkg::IFD_CLS_NOP : cls;
				nop_o <= lone_second || skip_pending_q;
				base_src_reg_o <= f_base;
				second_src_reg_o <= f_src;
				dest_reg_o <= f_dest;
				file_addr_o <= f_file;
				dest_is_default_work_reg_zero_o <= !f_destsel;
				literal_o <= f_lit;
				bit_from_base_src_reg_o <= (cls == ifd_pkg::IFD_CLS_BIT) && bit_from_reg_i;
				write_dest_o <= (cls != ifd_pkg::IFD_CLS_LIT) || (f_dest != f_base);
				// a word turned into a nop occupies exactly one cycle, whatever it encodes
				cycles_o <= (skip_taken || lone_second || skip_pending_q) ? 2'd1 :
					base_cycles;
				is_two_word_o <= 1'b0;
			end else if (accept && state_q == ifd_pkg::IFD_ST_SECOND) begin
				issue_o <= 1'b1;
				is_two_word_o <= 1'b1;
				long_word_o <= {first_q, word_i};
				cycles_o <= 2'd2;
				bad_second_o <= (opc != `IFD_OPC_NOP);
			end
		end
	end

	chk_stall_len: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_q == ifd_pkg::IFD_ST_SECOND && accept) |=> !word_ready_o ##1 word_ready_o)
		else $error("two-word stall length wrong");
	chk_orphan_nop: assert property (@(posedge clk_i) disable iff (reset_i)
		(accept && lone_second) |=> nop_o && issue_o)
		else $error("orphan second word not a nop");
	chk_two_word_cycles: assert property (@(posedge clk_i) disable iff (reset_i)
		(is_two_word_o && issue_o) |-> cycles_o == 2'd2)
		else $error("two-word cycle count wrong");
	chk_single_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
		(accept && state_q == ifd_pkg::IFD_ST_FIRST && base_cycles == 2'd1 &&
		!is_two_word(opc)) |=> word_ready_o)
		else $error("single-cycle word stalled");
	chk_branch_two: assert property (@(posedge clk_i) disable iff (reset_i)
		(accept && state_q == ifd_pkg::IFD_ST_FIRST && !skip_pending_q &&
		opc == `IFD_OPC_BRANCH_UNC) |=> !word_ready_o ##1 word_ready_o)
		else $error("unconditional branch not two cycles");
	chk_opcode_field: assert property (@(posedge clk_i) disable iff (reset_i)
		(accept && state_q == ifd_pkg::IFD_ST_FIRST) |=> opcode_o == $past(word_i[23:16]))
		else $error("opcode field mismatch");
	chk_skip_over: assert property (@(posedge clk_i) disable iff (reset_i)
		skip_taken |=> skip_pending_q)
		else $error("skip not recorded");
	chk_lit_dest: assert property (@(posedge clk_i) disable iff (reset_i)
		(issue_o && class_o == ifd_pkg::IFD_CLS_LIT && dest_reg_o == base_src_reg_o)
		|-> !write_dest_o)
		else $error("literal op wrote same register");
	chk_file_dest: assert property (@(posedge clk_i) disable iff (reset_i)
		(accept && state_q == ifd_pkg::IFD_ST_FIRST) |=>
		dest_is_default_work_reg_zero_o == !$past(word_i[13]))
		else $error("file destination selector wrong");
	chk_nop_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
		(issue_o && nop_o) |-> cycles_o == 2'd1)
		else $error("nop word reported more than one cycle");
endmodule : ifd_decoder

// *** tb/ifd_prog_mem.sv ***
// program memory model feeding instruction words to the decoder
`timescale 1ns/1ps
module ifd_prog_mem (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic word_ready_i,
	output logic word_valid_o,
	output logic [23:0] word_o,
	output logic cond_true_o,
	output logic bit_from_reg_o
);
	// each entry: {condition, bit select from register, 24-bit word}
	logic [25:0] mem [0:15];
	int len = 0;
	int ptr_q;
	assign word_valid_o = run_i && ptr_q < len;
	// idle bus shows inverted data so a stale word is never mistaken for a fresh one
	assign word_o = word_valid_o ? mem[ptr_q][23:0] : ~mem[ptr_q][23:0];
	assign cond_true_o = mem[ptr_q][25];
	assign bit_from_reg_o = mem[ptr_q][24];
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			ptr_q <= 0;
		else if (!run_i)
			ptr_q <= 0;
		else if (word_valid_o && word_ready_i)
			ptr_q <= ptr_q + 1;
	end
endmodule : ifd_prog_mem

// *** tb/ifd_decoder_bench.sv ***
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module ifd_decoder_bench;
	logic clk_i = 0, reset_i = 1, run_i = 0;
	logic word_valid_i, cond_true_i, bit_from_reg_i, word_ready_o, issue_o;
	logic [23:0] word_i;
	logic [7:0] opcode_o;
	ifd_pkg::ifd_class_e class_o;
	logic [3:0] base_src_reg_o, second_src_reg_o, dest_reg_o;
	logic [12:0] file_addr_o;
	logic dest_is_default_work_reg_zero_o, bit_from_base_src_reg_o, write_dest_o;
	logic [4:0] literal_o;
	logic [1:0] cycles_o;
	logic is_two_word_o, nop_o, bad_second_o;
	logic [47:0] long_word_o;
	int n_fail = 0, comparisons = 0, k = 0, n_exp = 0, cyc = 0, last = 0;
	// {opcode, cycles (0 ignores), nop, bad second, gap to previous issue (0 ignores)}
	logic [13:0] exp_q [0:15];
	ifd_prog_mem pm (.clk_i(clk_i), .reset_i(reset_i), .run_i(run_i),
		.word_ready_i(word_ready_o), .word_valid_o(word_valid_i), .word_o(word_i),
		.cond_true_o(cond_true_i), .bit_from_reg_o(bit_from_reg_i));
	ifd_decoder #(.TABLE_CYCLES(2)) uut (.clk_i(clk_i), .reset_i(reset_i),
		.word_valid_i(word_valid_i), .word_i(word_i), .cond_true_i(cond_true_i),
		.bit_from_reg_i(bit_from_reg_i), .word_ready_o(word_ready_o), .issue_o(issue_o),
		.opcode_o(opcode_o), .class_o(class_o), .base_src_reg_o(base_src_reg_o),
		.second_src_reg_o(second_src_reg_o), .dest_reg_o(dest_reg_o),
		.file_addr_o(file_addr_o),
		.dest_is_default_work_reg_zero_o(dest_is_default_work_reg_zero_o),
		.literal_o(literal_o), .bit_from_base_src_reg_o(bit_from_base_src_reg_o),
		.write_dest_o(write_dest_o), .cycles_o(cycles_o), .is_two_word_o(is_two_word_o),
		.long_word_o(long_word_o), .nop_o(nop_o), .bad_second_o(bad_second_o));
	initial forever #5 clk_i = ~clk_i;
	task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic summarize;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic put(input logic [25:0] v);
		pm.mem[pm.len] = v;
		pm.len++;
	endtask : put
	task automatic ex(input logic [7:0] op, input logic [1:0] c, input logic n,
			input logic b, input logic [1:0] g);
		exp_q[n_exp] = {op, c, n, b, g};
		n_exp++;
	endtask : ex
	// decode outputs are read at the falling edge, well clear of the update
	always @(negedge clk_i) begin
		cyc++;
		if (issue_o === 1'b1 && run_i && k < 16) begin
			cmp(opcode_o, exp_q[k][13:6]);
			if (exp_q[k][5:4] != 0) cmp(cycles_o, exp_q[k][5:4]);
			cmp(nop_o, exp_q[k][3]);
			cmp(bad_second_o, exp_q[k][2]);
			if (exp_q[k][1:0] != 0) cmp(cyc - last, exp_q[k][1:0]);
			last = cyc;
			k++;
		end
	end
	task automatic go(input string name);
		int i;
		k = 0;
		@(negedge clk_i) run_i = 1;
		for (i = 0; i < 60 && k < n_exp; i++)
			@(negedge clk_i);
		repeat (4) @(negedge clk_i);
		run_i = 0;
		cmp(k, n_exp);
		// a run that never finished is already counted above
		if (i == 60)
			summarize();
		$display("test %s done", name);
		pm.len = 0;
		n_exp = 0;
	endtask : go
	task automatic t_ctrl;
		put(26'h0370010); ex(8'h37, 2, 0, 0, 0);
		put(26'h0010002); ex(8'h01, 2, 0, 0, 2);
		put(26'h0ba0000); ex(8'hba, 2, 0, 0, 2);
		put(26'h0bb0000); ex(8'hbb, 2, 0, 0, 2);
		put(26'h2300004); ex(8'h30, 2, 0, 0, 2);
		put(26'h0300004); ex(8'h30, 1, 0, 0, 2);
		put(26'h0060000); ex(8'h06, 0, 0, 0, 1);
		go("control");
		cmp(cycles_o >= 2'd2, 1'b1);
	endtask : t_ctrl
	task automatic t_two;
		put(26'h0040100); put(26'h0000abc); ex(8'h04, 2, 0, 0, 0);
		put(26'h0021234); put(26'h0005678); ex(8'h02, 2, 0, 0, 3);
		put(26'h0000777); ex(8'h00, 1, 1, 0, 2);
		put(26'h0040000); put(26'h0550001); ex(8'h04, 0, 0, 1, 2);
		put(26'h0be0011); put(26'h0002222); ex(8'hbe, 2, 0, 0, 0);
		go("two_word");
		cmp(long_word_o, 48'hbe0011002222);
		cmp(is_two_word_o, 1'b1);
	endtask : t_two
	task automatic t_skip;
		put(26'h2a60000); ex(8'ha6, 1, 0, 0, 0);
		put(26'h0100000); ex(8'h10, 1, 1, 0, 1);
		put(26'h2a70000); ex(8'ha7, 1, 0, 0, 1);
		put(26'h0040000); put(26'h0000001); ex(8'h04, 1, 1, 0, 1);
		ex(8'h00, 1, 1, 0, 1);
		put(26'h0a60000); ex(8'ha6, 1, 0, 0, 1);
		put(26'h0100000); ex(8'h10, 1, 0, 0, 1);
		go("skip");
	endtask : t_skip
	task automatic t_fields;
		put(26'h0400abc); ex(8'h40, 1, 0, 0, 0); go("file_reg");
		cmp({class_o, file_addr_o}, {ifd_pkg::IFD_CLS_FILE, 13'h0abc});
		cmp(dest_is_default_work_reg_zero_o, 1'b1);
		put(26'h0402abc); ex(8'h40, 1, 0, 0, 0); go("file_dest");
		cmp(dest_is_default_work_reg_zero_o, 1'b0);
		put(26'h0105a93); ex(8'h10, 0, 0, 0, 0); go("work_reg");
		cmp({base_src_reg_o, second_src_reg_o, dest_reg_o}, 12'hb35);
		put(26'h1a001f0); ex(8'ha0, 1, 0, 0, 0); go("bit");
		cmp({class_o, bit_from_base_src_reg_o, literal_o}, {ifd_pkg::IFD_CLS_BIT, 6'h3f});
		put(26'h0b00880); ex(8'hb0, 1, 0, 0, 0); go("lit_same");
		cmp({write_dest_o, base_src_reg_o}, 5'h01);
		put(26'h0b00900); ex(8'hb0, 1, 0, 0, 0); go("lit_other");
		cmp({write_dest_o, base_src_reg_o}, 5'h11);
	endtask : t_fields
	initial begin
		repeat (8) @(posedge clk_i);
		@(negedge clk_i) reset_i = 0;
		cmp({word_ready_o, issue_o}, 2'b10);
		t_ctrl();
		t_two();
		t_skip();
		t_fields();
		summarize();
	end
endmodule : ifd_decoder_bench
